// file: logic/dtcdl_pkg.sv
// Package with descriptor layout, field positions and mode encodings
package dtcdl_pkg;
  // Mode word field positions
  localparam int SRC_STEP_POS = 14;
  localparam int DST_STEP_POS = 12;
  localparam int MODE_POS = 10;
  localparam int SIZE_POS = 8;
  localparam int AREA_SEL_POS = 7;
  localparam int CHAIN_POS = 6;
  localparam int IRQ_SEL_POS = 5;
  localparam int NMI_MODE_POS = 4;
  // Descriptor word byte offsets in on-chip RAM
  localparam logic [31:0] DESC_MODE_COUNT_OFF = 32'h0000_0000;
  localparam logic [31:0] DESC_SRC_OFF = 32'h0000_0004;
  localparam logic [31:0] DESC_DST_OFF = 32'h0000_0008;
  localparam logic [31:0] DESC_INIT_OFF = 32'h0000_000c;
  localparam logic [31:0] DESC_BLEN_OFF = 32'h0000_0010;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0014;
  localparam logic [2:0] DESC_LAST_LOAD = 3'h4;
  localparam logic [2:0] DESC_LAST_WBACK = 3'h2;
  // A zero count means the full range
  localparam logic [16:0] FULL_RANGE_16 = 17'h1_0000;
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 8;
  // Transfer modes
  typedef enum logic [1:0] {
    XFER_NORMAL = 2'b00,
    XFER_REPEAT = 2'b01,
    XFER_BLOCK = 2'b10,
    XFER_BAD = 2'b11
  } dtcdl_mode_t;
  // Unit sizes
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10,
    SIZE_BAD = 2'b11
  } dtcdl_size_t;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_UPDATE = 3'b100,
    ST_WBACK = 3'b101
  } dtcdl_state_t;
endpackage : dtcdl_pkg

// file: logic/dtcdl_engine.sv
// Descriptor-driven transfer engine with its staging FIFO
// Contract
// - Area-select 0 makes destination the repeat/block area, 1 makes source.
// - Chain-enable 1 loads and runs the next descriptor in the same activation.
// - Chained transfers skip end check, source flag clear and enable clear.
// - Interrupt-select 1 interrupts every transfer; 0 only when the count ends.
// - NMI with NMI-mode 0 stops the transfer; with 1 it runs to completion.
// - Source address is a full 32-bit field.
// - Destination address is a full 32-bit field.
// - Repeat mode initial address holds repeat area start, chosen by area-select.
// - Normal mode count decrements per transfer and ends at zero.
// - Normal count 1 is one transfer, all-ones 65535, zero 65536.
// - Repeat mode: upper count half is reload, lower half counts.
// - Block mode count is 16 bits: 1 one, all-ones 65535, zero 65536.
// - Mode field 00 normal, 01 repeat, 10 block, 11 prohibited.
// - Size field 00 byte, 01 word, 10 longword, 11 prohibited.
// - Address step mode 0x fixed, 10 increment, 11 decrement by size.
// - Block length field gives units per block, zero meaning 65536.

// Synchronous FIFO staging read data ahead of writes
module dtcdl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] fill_q, fill_d;
  logic push, pop;

  // Handshakes and next pointers
  always_comb begin
    in_ready = (fill_q != (AW+1)'(DEPTH));
    out_valid = (fill_q != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_d = push ? ((wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1) : wr_ptr_q;
    rd_ptr_d = pop ? ((rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1) : rd_ptr_q;
    fill_d = fill_q + (AW+1)'(push) - (AW+1)'(pop);
    out_data = mem_q[rd_ptr_q];
  end

  // Pointer and occupancy registers
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      fill_q <= fill_d;
    end
  end

  // Storage, one entry per generate step
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (push && wr_ptr_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule : dtcdl_fifo

// Engine: loads a descriptor, moves data, updates counts, writes back
module dtcdl_engine (
  input wire logic clock,
  input wire logic rst,
  input wire logic act_valid,
  output logic act_ready,
  input wire logic [31:0] act_base,
  input wire logic nmi,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic cpu_irq,
  output logic clear_source_flag,
  output logic clear_enable_bit,
  output logic nmi_abort,
  output logic done,
  output logic busy
);
  import dtcdl_pkg::*;

  dtcdl_state_t state_q, state_d;
  logic [15:0] mode_q, mode_d, cnt_q, cnt_d, blen_q, blen_d;
  logic [31:0] src_q, src_d, dst_q, dst_d, iar_q, iar_d, area_q, area_d, base_q, base_d;
  logic [2:0] idx_q, idx_d;
  logic [16:0] rd_left_q, rd_left_d, wr_left_q, wr_left_d;
  logic stop_q, stop_d, irq_q, irq_d, clr_src_q, clr_src_d, clr_en_q, clr_en_d;
  logic abort_q, abort_d, done_q, done_d;
  logic fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop;
  logic [31:0] fifo_out_data;
  dtcdl_mode_t xmode;
  logic [31:0] step;
  logic area_src, chain, irq_sel, nmi_cont, end_cnt;
  logic [16:0] units;

  // Size step and address update
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] how,
                                            input logic [31:0] stp);
    if (!how[1]) begin
      next_addr = a;
    end else if (!how[0]) begin
      next_addr = a + stp;
    end else begin
      next_addr = a - stp;
    end
  endfunction : next_addr

  dtcdl_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Field decode; mode bits 3..0 are never looked at
  always_comb begin
    xmode = dtcdl_mode_t'(mode_q[MODE_POS +: 2]);
    area_src = mode_q[AREA_SEL_POS];
    chain = mode_q[CHAIN_POS];
    irq_sel = mode_q[IRQ_SEL_POS];
    nmi_cont = mode_q[NMI_MODE_POS];
    unique case (dtcdl_size_t'(mode_q[SIZE_POS +: 2]))
      SIZE_BYTE: step = 32'h0000_0001;
      SIZE_WORD: step = 32'h0000_0002;
      SIZE_LONG: step = 32'h0000_0004;
      default: step = 32'h0000_0001;
    endcase
    // Block length arrives with the last load word; zero means the full range
    units = (mem_rdata[15:0] == 16'h0000) ? FULL_RANGE_16 : {1'b0, mem_rdata[15:0]};
  end

  // Next-state logic for the whole engine
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    blen_d = blen_q;
    src_d = src_q;
    dst_d = dst_q;
    iar_d = iar_q;
    area_d = area_q;
    base_d = base_q;
    idx_d = idx_q;
    rd_left_d = rd_left_q;
    wr_left_d = wr_left_q;
    stop_d = stop_q;
    irq_d = 1'b0;
    clr_src_d = 1'b0;
    clr_en_d = 1'b0;
    abort_d = 1'b0;
    done_d = 1'b0;
    end_cnt = 1'b0;
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = 32'h0000_0000;
    mem_size = SIZE_LONG;
    mem_wdata = 32'h0000_0000;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    act_ready = (state_q == ST_IDLE);
    unique case (state_q)
      ST_IDLE: begin
        if (act_valid) begin
          base_d = act_base;
          idx_d = 3'h0;
          stop_d = 1'b0;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        mem_req = 1'b1;
        mem_addr = base_q + {27'h0, idx_q, 2'b00};
        if (mem_ack) begin
          unique case (idx_q)
            3'h0: begin
              mode_d = mem_rdata[31:16];
              cnt_d = mem_rdata[15:0];
            end
            3'h1: src_d = mem_rdata;
            3'h2: dst_d = mem_rdata;
            3'h3: iar_d = mem_rdata;
            default: blen_d = mem_rdata[15:0];
          endcase
          idx_d = idx_q + 3'h1;
          if (idx_q == DESC_LAST_LOAD) begin
            // Block mode moves a whole block per activation
            rd_left_d = (xmode == XFER_BLOCK) ? units : 17'h0_0001;
            wr_left_d = rd_left_d;
            area_d = area_src ? src_q : dst_q;
            state_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (nmi && !nmi_cont) begin
          stop_d = 1'b1;
        end
        if (rd_left_q == 17'h0_0000 || stop_d || !fifo_in_ready) begin
          state_d = ST_WRITE;
        end else begin
          mem_req = 1'b1;
          mem_addr = src_q;
          mem_size = mode_q[SIZE_POS +: 2];
          fifo_push = mem_ack;
          if (mem_ack) begin
            src_d = next_addr(src_q, mode_q[SRC_STEP_POS +: 2], step);
            rd_left_d = rd_left_q - 17'h0_0001;
          end
        end
      end
      ST_WRITE: begin
        if (fifo_out_valid) begin
          mem_req = 1'b1;
          mem_we = 1'b1;
          mem_addr = dst_q;
          mem_size = mode_q[SIZE_POS +: 2];
          mem_wdata = fifo_out_data;
          fifo_pop = mem_ack;
          if (mem_ack) begin
            dst_d = next_addr(dst_q, mode_q[DST_STEP_POS +: 2], step);
            wr_left_d = wr_left_q - 17'h0_0001;
          end
        end else if (stop_q) begin
          abort_d = 1'b1;
          idx_d = 3'h0;
          state_d = ST_WBACK;
        end else begin
          state_d = (wr_left_q == 17'h0_0000) ? ST_UPDATE : ST_READ;
        end
      end
      ST_UPDATE: begin
        unique case (xmode)
          XFER_REPEAT: begin
            cnt_d[7:0] = cnt_q[7:0] - 8'h01;
            if (cnt_d[7:0] == 8'h00) begin
              cnt_d[7:0] = cnt_q[15:8];
              if (area_src) begin
                src_d = iar_q;
              end else begin
                dst_d = iar_q;
              end
            end
          end
          XFER_BLOCK: begin
            cnt_d = cnt_q - 16'h0001;
            end_cnt = (cnt_d == 16'h0000);
            if (area_src) begin
              src_d = area_q;
            end else begin
              dst_d = area_q;
            end
          end
          default: begin
            cnt_d = cnt_q - 16'h0001;
            end_cnt = (cnt_d == 16'h0000);
          end
        endcase
        // Chained transfers skip the end check and both clears
        if (!chain) begin
          irq_d = irq_sel || end_cnt;
          clr_en_d = irq_sel || end_cnt;
          clr_src_d = !(irq_sel || end_cnt);
        end
        idx_d = 3'h0;
        state_d = ST_WBACK;
      end
      ST_WBACK: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = base_q + {27'h0, idx_q, 2'b00};
        unique case (idx_q)
          3'h0: mem_wdata = {mode_q, cnt_q};
          3'h1: mem_wdata = src_q;
          default: mem_wdata = dst_q;
        endcase
        if (mem_ack) begin
          idx_d = idx_q + 3'h1;
          if (idx_q == DESC_LAST_WBACK) begin
            idx_d = 3'h0;
            if (chain && !stop_q) begin
              base_d = base_q + DESC_BYTES;
              state_d = ST_LOAD;
            end else begin
              done_d = 1'b1;
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State registers; reset clears descriptor contents to zero until loaded
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      mode_q <= 16'h0000;
      cnt_q <= 16'h0000;
      blen_q <= 16'h0000;
      src_q <= 32'h0000_0000;
      dst_q <= 32'h0000_0000;
      iar_q <= 32'h0000_0000;
      area_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
      idx_q <= 3'h0;
      rd_left_q <= 17'h0_0000;
      wr_left_q <= 17'h0_0000;
      stop_q <= 1'b0;
      irq_q <= 1'b0;
      clr_src_q <= 1'b0;
      clr_en_q <= 1'b0;
      abort_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      blen_q <= blen_d;
      src_q <= src_d;
      dst_q <= dst_d;
      iar_q <= iar_d;
      area_q <= area_d;
      base_q <= base_d;
      idx_q <= idx_d;
      rd_left_q <= rd_left_d;
      wr_left_q <= wr_left_d;
      stop_q <= stop_d;
      irq_q <= irq_d;
      clr_src_q <= clr_src_d;
      clr_en_q <= clr_en_d;
      abort_q <= abort_d;
      done_q <= done_d;
    end
  end

  // Registered event outputs
  assign cpu_irq = irq_q;
  assign clear_source_flag = clr_src_q;
  assign clear_enable_bit = clr_en_q;
  assign nmi_abort = abort_q;
  assign done = done_q;
  assign busy = (state_q != ST_IDLE);
endmodule : dtcdl_engine

// file: tb/dtcdl_mem_model.sv
// Behavioural on-chip RAM that holds descriptors and data
module dtcdl_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [256];
  logic [3:0] wait_q;
  // Answer after slow wait cycles; an idle data bus shows the inverted last value
  always @(posedge clock) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_q >= slow) begin
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[9:2]];
    end else if (mem_req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : dtcdl_mem_model

// file: tb/dtcdl_monitor.sv
// Port checker for the transfer engine
module dtcdl_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic act_valid,
  input wire logic act_ready,
  input wire logic [31:0] act_base,
  input wire logic nmi,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic cpu_irq,
  input wire logic clear_source_flag,
  input wire logic clear_enable_bit,
  input wire logic nmi_abort,
  input wire logic done,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Request and event relations
  a_start_fetch: assert property (
    act_valid && act_ready |=> mem_req && !mem_we && mem_addr == $past(act_base))
    else $error("descriptor fetch missing");
  a_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed early");
  a_idle_quiet: assert property (
    !busy |-> !mem_req && act_ready)
    else $error("request while idle");
  a_abort_quiet: assert property (
    nmi_abort |-> !cpu_irq && !clear_enable_bit)
    else $error("abort with interrupt");
  a_clear_irq: assert property (
    clear_enable_bit |-> cpu_irq)
    else $error("enable cleared without interrupt");
  a_irq_wback: assert property (
    cpu_irq |-> mem_req && mem_we && mem_size == 2'h2 ##1 !cpu_irq)
    else $error("interrupt outside write-back");
  a_done_idle: assert property (
    done |-> act_ready && !busy ##1 !done)
    else $error("done while busy");
  a_done_bound: assert property (
    act_valid && act_ready |-> ##[1:1000] done)
    else $error("activation never finished");
  c_abort: cover property (nmi_abort);
  c_irq: cover property (cpu_irq && clear_enable_bit);
  c_slow: cover property (mem_req && !mem_ack ##1 mem_ack);
endmodule : dtcdl_monitor

bind dtcdl_engine dtcdl_monitor u_mon (.clock(clock), .rst(rst), .act_valid(act_valid),
  .act_ready(act_ready), .act_base(act_base), .nmi(nmi), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack), .cpu_irq(cpu_irq),
  .clear_source_flag(clear_source_flag), .clear_enable_bit(clear_enable_bit),
  .nmi_abort(nmi_abort), .done(done), .busy(busy));

// file: tb/testbench.sv
// Self-checking bench for the descriptor transfer engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtcdl_pkg::*;
  logic clock, rst, act_valid, act_ready, nmi, mem_req, mem_we, mem_ack;
  logic [31:0] act_base, mem_addr, mem_wdata, mem_rdata;
  logic [1:0] mem_size;
  logic cpu_irq, clear_source_flag, clear_enable_bit, nmi_abort, done, busy;
  logic [3:0] slow;
  int failures, total_checks, n_irq, n_cs, n_ce, n_ab;
  dtcdl_engine u_dut (.clock(clock), .rst(rst), .act_valid(act_valid), .act_ready(act_ready),
    .act_base(act_base), .nmi(nmi), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_irq(cpu_irq), .clear_source_flag(clear_source_flag),
    .clear_enable_bit(clear_enable_bit), .nmi_abort(nmi_abort), .done(done), .busy(busy));
  dtcdl_mem_model u_mem (.clock(clock), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Count event pulses
  always @(posedge clock) begin
    if (cpu_irq === 1'b1) n_irq++;
    if (clear_source_flag === 1'b1) n_cs++;
    if (clear_enable_bit === 1'b1) n_ce++;
    if (nmi_abort === 1'b1) n_ab++;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task stop_test;
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  function automatic logic [15:0] mw(input logic [1:0] sm, dm, md, sz, input logic [3:0] f);
    return {sm, dm, md, sz, f, 4'h0};
  endfunction : mw
  // Program one whole descriptor in RAM
  task desc(input logic [7:0] i, input logic [15:0] m, c, input logic [31:0] s, d, ia, bl);
    u_mem.mem[i] = {m, c};
    u_mem.mem[i + 8'h1] = s;
    u_mem.mem[i + 8'h2] = d;
    u_mem.mem[i + 8'h3] = ia;
    u_mem.mem[i + 8'h4] = bl;
  endtask : desc
  task run;
    int k;
    n_irq = 0;
    n_cs = 0;
    n_ce = 0;
    n_ab = 0;
    @(negedge clock);
    act_base = 32'h0;
    act_valid = 1'b1;
    @(negedge clock);
    act_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    // A run that never finishes counts as a mismatch
    if (done !== 1'b1) begin
      failures++;
    end
    @(negedge clock);
  endtask : run
  // Compare written-back descriptor and event counts
  task res(input logic [7:0] i, input logic [15:0] c, input logic [31:0] s, d, ir, cs, ce);
    check("count", {16'h0, u_mem.mem[i][15:0]}, {16'h0, c});
    check("source", u_mem.mem[i + 8'h1], s);
    check("dest", u_mem.mem[i + 8'h2], d);
    check("irq", n_irq, ir);
    check("clr_src", n_cs, cs);
    check("clr_en", n_ce, ce);
  endtask : res
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    act_valid = 1'b0;
    act_base = 32'h0;
    nmi = 1'b0;
    slow = 4'h0;
    failures = 0;
    total_checks = 0;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    u_mem.mem[8'h80] = 32'hcafe_f00d;
    u_mem.mem[8'h81] = 32'h1234_5678;
    desc(8'h0, mw(2'h2, 2'h2, 2'h0, 2'h2, 4'h0), 16'h1,
      32'ha000_0200, 32'h5000_0300, 0, 0);
    run();
    res(8'h0, 16'h0, 32'ha000_0204, 32'h5000_0304, 1, 0, 1);
    check("data", u_mem.mem[8'hc0], 32'hcafe_f00d);
    slow = 4'h3;
    desc(8'h0, mw(2'h3, 2'h0, 2'h0, 2'h1, 4'h0) | 16'h000f, 16'h2,
      32'h20e, 32'h310, 0, 0);
    run();
    res(8'h0, 16'h1, 32'h20c, 32'h310, 0, 1, 0);
    desc(8'h0, mw(2'h2, 2'h3, 2'h0, 2'h0, 4'h2), 16'h0, 32'h201, 32'h305, 0, 0);
    run();
    res(8'h0, 16'hffff, 32'h202, 32'h304, 1, 0, 1);
    slow = 4'h0;
    desc(8'h0, mw(2'h0, 2'h2, 2'h1, 2'h2, 4'h0), 16'h0301, 32'h200, 32'h300, 32'h340, 0);
    run();
    res(8'h0, 16'h0303, 32'h200, 32'h340, 0, 1, 0);
    desc(8'h0, mw(2'h2, 2'h0, 2'h1, 2'h2, 4'h8), 16'h0201, 32'h200, 32'h300, 32'h260, 0);
    run();
    res(8'h0, 16'h0202, 32'h260, 32'h300, 0, 1, 0);
    slow = 4'h2;
    desc(8'h0, mw(2'h2, 2'h2, 2'h2, 2'h2, 4'h8), 16'h5, 32'h200, 32'h300, 0, 32'h2);
    run();
    res(8'h0, 16'h4, 32'h200, 32'h308, 0, 1, 0);
    check("block", u_mem.mem[8'hc1], 32'h1234_5678);
    slow = 4'h0;
    desc(8'h0, mw(2'h2, 2'h2, 2'h0, 2'h2, 4'h4), 16'h1, 32'h200, 32'h320, 0, 0);
    desc(8'h5, mw(2'h2, 2'h2, 2'h0, 2'h2, 4'h0), 16'h3, 32'h204, 32'h330, 0, 0);
    run();
    res(8'h0, 16'h0, 32'h204, 32'h324, 0, 1, 0);
    res(8'h5, 16'h2, 32'h208, 32'h334, 0, 1, 0);
    for (int m = 0; m < 2; m++) begin
      desc(8'h0, mw(2'h2, 2'h2, 2'h2, 2'h2, {3'h0, m[0]}), 16'h3, 32'h200, 32'h340, 0, 32'h8);
      nmi = 1'b1;
      run();
      nmi = 1'b0;
      check("nmi_count", {16'h0, u_mem.mem[8'h0][15:0]}, m ? 32'h2 : 32'h3);
      check("nmi_abort", n_ab, m ? 32'h0 : 32'h1);
    end
    stop_test();
  end
endmodule : testbench
